// *** logic/sap_pkg.sv ***
// Constants, field layouts and carrier types for the stored address pointer controller.
// Assumes a 16-bit word memory with a 10-bit USER address space behind the controller.
package sap_pkg;

  // Memory banks and word addresses of the write request.
  localparam logic [1:0]  USER_BANK     = 2'h3;
  localparam logic [13:0] REDIRECT_ADDR = 14'h3FFF;
  localparam logic [13:0] CTRL_ADDR     = 14'h0002;
  localparam logic [13:0] PTR_ADDR      = 14'h0003;
  localparam logic [3:0]  ADDR_HI_ZERO  = 4'h0;

  // USER data area, word addresses and reset values of the pointer and control words.
  localparam logic [9:0]  USER_START    = 10'h006;
  localparam logic [9:0]  PTR_WORD_ADDR = 10'h003;
  localparam logic [9:0]  CTRL_WORD_ADDR = 10'h002;
  localparam logic [15:0] PTR_RESET     = 16'h0006;
  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  localparam logic [9:0]  ONE_WORD      = 10'h001;
  localparam logic [7:0]  ONE_BLOCK     = 8'h01;

  // Bit positions in the pointer word and the control word; only the lock pair sits in both.
  localparam int LOCK_BIT      = 15;
  localparam int PLOCK_BIT     = 14;
  localparam int INIT_LOAD_BIT = 10;
  localparam int ADDR_MSB      = 9;
  localparam int MWW_BIT       = 7;
  localparam int BSIZE_MSB     = 6;
  localparam int BSIZE_LSB     = 4;
  localparam int WRAP_FLAG_BIT = 3;
  localparam int WRAP_EN_BIT   = 2;
  localparam int ALOCK_BIT     = 1;
  localparam int ADV_BIT       = 0;

  // Lock pair encodings {lock, permanent lock}.
  localparam logic [1:0] PAIR_OPEN       = 2'h0;
  localparam logic [1:0] PAIR_PERM_OPEN  = 2'h1;
  localparam logic [1:0] PAIR_SECURED    = 2'h2;

  // Free USER words per block size code.
  localparam logic [9:0] FREE_WORDS [0:7] = '{10'h3A3, 10'h3C3, 10'h3D3, 10'h3DB,
                                              10'h3DF, 10'h3E1, 10'h3E1, 10'h3E1};

  typedef struct packed {
    logic [1:0]  bank;
    logic [13:0] addr;
    logic [15:0] data;
  } wr_req_s;

  typedef struct packed {
    logic [9:0]  addr;
    logic [15:0] data;
  } mem_wr_s;

  typedef enum logic [1:0] {
    ST_INIT_REQ,
    ST_INIT_WAIT,
    ST_IDLE,
    ST_PTR_SAVE
  } ctrl_state_e;

endpackage

// *** logic/word_lock_gate.sv ***
// Write permission check for a self-locking register word.
// Assumes the caller supplies the stored lock pair and the pair carried by the new data.
`timescale 1ns/1ps
module word_lock_gate (
  // Lock state
  input  wire logic [1:0] cur_pair,
  input  wire logic [1:0] new_pair,
  input  wire logic       secured,
  // Verdict
  output logic            write_ok
);

  // A locked or permanently unlocked word must be rewritten with its own pair.
  assign write_ok = (cur_pair == sap_pkg::PAIR_OPEN) ? 1'b1 :
                    (cur_pair == sap_pkg::PAIR_PERM_OPEN) ? (new_pair == sap_pkg::PAIR_PERM_OPEN) :
                    (cur_pair == sap_pkg::PAIR_SECURED) ?
                      (secured && (new_pair == sap_pkg::PAIR_SECURED)) :
                    1'b0;

endmodule

// *** logic/stored_address_pointer_ctrl.sv ***
// Stored address pointer controller: redirect writes, pointer advance, wrap and span lock.
// Assumes one write request at a time from the air or serial front end, and an NVM read
// port that returns the control and pointer words once after reset.
`timescale 1ns/1ps
module stored_address_pointer_ctrl (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rstn,
  // Power-on load from nonvolatile memory
  output logic                   nv_rd_req,
  input  wire logic              nv_rd_valid,
  input  wire logic [15:0]       nv_ctrl_word,
  input  wire logic [15:0]       nv_ptr_word,
  // Write requests from the front end
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire sap_pkg::wr_req_s  req,
  input  wire logic              secured,
  output logic                   resp_ok,
  output logic                   resp_err,
  // USER memory write port
  output logic                   mem_we,
  output sap_pkg::mem_wr_s       mem_wr,
  // Register views and derived settings
  output logic [15:0]            ctrl_word,
  output logic [15:0]            pointer_word,
  output logic [9:0]             initial_pointer,
  output logic                   multi_word_write_enable,
  output logic [7:0]             block_words,
  output logic [9:0]             free_words,
  output logic                   wrap_occurred_flag
);

  sap_pkg::ctrl_state_e state;
  sap_pkg::ctrl_state_e next_state;

  // Stored fields.
  logic [1:0] ctrl_pair;
  logic       mww_stored;
  logic [2:0] block_size_field;
  logic       wrap_enable;
  logic       trailing_span_lock;
  logic       pointer_advance_enable;
  logic [1:0] ptr_pair;
  logic [9:0] ptr;

  assign ctrl_word    = {ctrl_pair, 6'h00, mww_stored, block_size_field, wrap_occurred_flag,
                         wrap_enable, trailing_span_lock, pointer_advance_enable};
  assign pointer_word = {ptr_pair, 4'h0, ptr};

  assign block_words = sap_pkg::ONE_BLOCK << block_size_field;
  assign free_words  = sap_pkg::FREE_WORDS[block_size_field];

  wire [9:0] last_loc = sap_pkg::USER_START + free_words - sap_pkg::ONE_WORD;

  // Request decode.
  wire        take        = req_valid && req_ready;
  wire        is_user     = req.bank == sap_pkg::USER_BANK;
  wire        is_redirect = is_user && (req.addr == sap_pkg::REDIRECT_ADDR);
  wire        is_ctrl     = is_user && (req.addr == sap_pkg::CTRL_ADDR);
  wire        is_ptr      = is_user && (req.addr == sap_pkg::PTR_ADDR);
  wire        is_plain    = is_user && (req.addr[13:10] == sap_pkg::ADDR_HI_ZERO)
                            && !is_ctrl && !is_ptr;
  wire [9:0]  req_loc     = req.addr[9:0];

  // Lock gates for the control word and the pointer word.
  wire [1:0] gate_ok;
  wire [1:0] gate_cur [0:1];
  assign gate_cur[0] = ctrl_pair;
  assign gate_cur[1] = ptr_pair;

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_gate
      word_lock_gate u_gate (
        .cur_pair (gate_cur[g]),
        .new_pair (req.data[sap_pkg::LOCK_BIT:sap_pkg::PLOCK_BIT]),
        .secured  (secured),
        .write_ok (gate_ok[g])
      );
    end
  endgenerate

  // Locked span and pointer targeting.
  wire span_hit  = trailing_span_lock && (req_loc >= sap_pkg::USER_START)
                   && (req_loc <= ptr);
  wire ptr_in    = (ptr >= sap_pkg::USER_START) && (ptr <= last_loc);
  wire at_end    = ptr == last_loc;
  wire wrap_eff  = wrap_enable && !trailing_span_lock;
  wire ptr_in_span = trailing_span_lock; // Pointer location itself is always in the span.
  wire [9:0] adv_loc = at_end ? sap_pkg::USER_START : ptr + sap_pkg::ONE_WORD;
  // Advance refuses at the end unless wrapping; no advance keeps the pointer.
  wire redir_ok  = ptr_in && (pointer_advance_enable ? (!at_end || wrap_eff)
                                                     : !ptr_in_span);
  wire [9:0] redir_loc = pointer_advance_enable ? adv_loc : ptr;
  wire wrap_set  = take && is_redirect && redir_ok && pointer_advance_enable && at_end
                   && wrap_enable && !trailing_span_lock;

  wire accept = is_redirect ? redir_ok :
                is_ctrl     ? gate_ok[0] :
                is_ptr      ? gate_ok[1] :
                is_plain    ? !span_hit :
                1'b0;

  wire ctrl_wr   = take && is_ctrl && gate_ok[0];
  wire ptr_wr    = take && is_ptr && gate_ok[1];
  wire ptr_adv   = take && is_redirect && redir_ok && pointer_advance_enable;
  wire flag_clr  = ctrl_wr && !req.data[sap_pkg::WRAP_FLAG_BIT];
  wire init_done = (state == sap_pkg::ST_INIT_WAIT) && nv_rd_valid;

  assign req_ready = state == sap_pkg::ST_IDLE;
  assign nv_rd_req = state == sap_pkg::ST_INIT_WAIT;

  // Word presented to memory for an accepted request.
  wire [15:0] ctrl_new = {req.data[sap_pkg::LOCK_BIT:sap_pkg::PLOCK_BIT], 6'h00,
                          req.data[sap_pkg::MWW_BIT:sap_pkg::BSIZE_LSB],
                          wrap_set || (wrap_occurred_flag && !flag_clr),
                          req.data[sap_pkg::WRAP_EN_BIT:sap_pkg::ADV_BIT]};
  wire [15:0] ptr_new  = {req.data[sap_pkg::LOCK_BIT:sap_pkg::PLOCK_BIT], 4'h0,
                          req.data[sap_pkg::ADDR_MSB:0]};
  wire sap_pkg::mem_wr_s next_mem_wr =
      is_redirect ? sap_pkg::mem_wr_s'{addr: redir_loc, data: req.data} :
      is_ctrl     ? sap_pkg::mem_wr_s'{addr: sap_pkg::CTRL_WORD_ADDR, data: ctrl_new} :
      is_ptr      ? sap_pkg::mem_wr_s'{addr: sap_pkg::PTR_WORD_ADDR, data: ptr_new} :
                    sap_pkg::mem_wr_s'{addr: req_loc, data: req.data};

  always_comb
  begin
    next_state = state;
    case (state)
      sap_pkg::ST_INIT_REQ:  next_state = sap_pkg::ST_INIT_WAIT;
      sap_pkg::ST_INIT_WAIT: if (nv_rd_valid) next_state = sap_pkg::ST_IDLE;
      sap_pkg::ST_IDLE:      if (ptr_adv) next_state = sap_pkg::ST_PTR_SAVE;
      sap_pkg::ST_PTR_SAVE:  next_state = sap_pkg::ST_IDLE;
      default:               next_state = sap_pkg::ST_INIT_REQ;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
      state <= sap_pkg::ST_INIT_REQ;
    else
      state <= next_state;
  end

  // Write port and response strobes.
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      mem_we   <= 1'b0;
      mem_wr   <= '0;
      resp_ok  <= 1'b0;
      resp_err <= 1'b0;
    end
    else if (state == sap_pkg::ST_PTR_SAVE)
    begin
      // The advanced pointer is stored back so it survives a power cycle.
      mem_we   <= 1'b1;
      mem_wr   <= '{addr: sap_pkg::PTR_WORD_ADDR, data: pointer_word};
      resp_ok  <= 1'b0;
      resp_err <= 1'b0;
    end
    else
    begin
      mem_we   <= take && accept;
      mem_wr   <= next_mem_wr;
      resp_ok  <= take && accept;
      resp_err <= take && !accept;
    end
  end

  // Control word fields.
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      ctrl_pair               <= sap_pkg::CTRL_RESET[sap_pkg::LOCK_BIT:sap_pkg::PLOCK_BIT];
      mww_stored              <= 1'b0;
      multi_word_write_enable <= 1'b0;
      block_size_field        <= sap_pkg::CTRL_RESET[sap_pkg::BSIZE_MSB:sap_pkg::BSIZE_LSB];
      wrap_enable             <= 1'b0;
      trailing_span_lock      <= 1'b0;
      pointer_advance_enable  <= 1'b0;
    end
    else if (init_done)
    begin
      ctrl_pair               <= nv_ctrl_word[sap_pkg::LOCK_BIT:sap_pkg::PLOCK_BIT];
      mww_stored              <= nv_ctrl_word[sap_pkg::MWW_BIT];
      multi_word_write_enable <= nv_ctrl_word[sap_pkg::MWW_BIT];
      block_size_field        <= nv_ctrl_word[sap_pkg::BSIZE_MSB:sap_pkg::BSIZE_LSB];
      wrap_enable             <= nv_ctrl_word[sap_pkg::WRAP_EN_BIT];
      trailing_span_lock      <= nv_ctrl_word[sap_pkg::ALOCK_BIT];
      pointer_advance_enable  <= nv_ctrl_word[sap_pkg::ADV_BIT];
    end
    else if (ctrl_wr)
    begin
      // The stored enable changes now, the effective one only at the next power-up.
      ctrl_pair               <= ctrl_new[sap_pkg::LOCK_BIT:sap_pkg::PLOCK_BIT];
      mww_stored              <= ctrl_new[sap_pkg::MWW_BIT];
      block_size_field        <= ctrl_new[sap_pkg::BSIZE_MSB:sap_pkg::BSIZE_LSB];
      wrap_enable             <= ctrl_new[sap_pkg::WRAP_EN_BIT];
      trailing_span_lock      <= ctrl_new[sap_pkg::ALOCK_BIT];
      pointer_advance_enable  <= ctrl_new[sap_pkg::ADV_BIT];
    end
  end

  // Wrap flag: a wrap in the same cycle as a clear keeps the flag set.
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      wrap_occurred_flag <= 1'b0;
    else if (init_done)
      wrap_occurred_flag <= nv_ctrl_word[sap_pkg::WRAP_FLAG_BIT];
    else if (wrap_set)
      wrap_occurred_flag <= 1'b1;
    else if (flag_clr)
      wrap_occurred_flag <= 1'b0;
  end

  // Pointer word and initial pointer.
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      ptr_pair        <= sap_pkg::PTR_RESET[sap_pkg::LOCK_BIT:sap_pkg::PLOCK_BIT];
      ptr             <= sap_pkg::PTR_RESET[sap_pkg::ADDR_MSB:0];
      initial_pointer <= sap_pkg::USER_START;
    end
    else if (init_done)
    begin
      ptr_pair <= nv_ptr_word[sap_pkg::LOCK_BIT:sap_pkg::PLOCK_BIT];
      ptr      <= nv_ptr_word[sap_pkg::ADDR_MSB:0];
    end
    else if (ptr_wr)
    begin
      ptr_pair <= ptr_new[sap_pkg::LOCK_BIT:sap_pkg::PLOCK_BIT];
      ptr      <= ptr_new[sap_pkg::ADDR_MSB:0];
      if (req.data[sap_pkg::INIT_LOAD_BIT])
        initial_pointer <= req.data[sap_pkg::ADDR_MSB:0];
    end
    else if (ptr_adv)
      ptr <= adv_loc;
  end

endmodule

// *** bench/sap_checker_sva.sv ***
// Checker for the stored address pointer controller, bound to its top module.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ps
module sap_checker (
  // Clock and reset
  input wire logic             mclk,
  input wire logic             rstn,
  // Load and requests
  input wire logic             nv_rd_req,
  input wire logic             nv_rd_valid,
  input wire logic             req_valid,
  input wire logic             req_ready,
  input wire sap_pkg::wr_req_s req,
  input wire logic             resp_ok,
  input wire logic             resp_err,
  input wire logic             mem_we,
  input wire sap_pkg::mem_wr_s mem_wr,
  // Views
  input wire logic [15:0]      ctrl_word,
  input wire logic [15:0]      pointer_word,
  input wire logic             multi_word_write_enable,
  input wire logic [7:0]       block_words,
  input wire logic [9:0]       free_words
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  wire [9:0] ptr  = pointer_word[9:0];
  wire [9:0] last = sap_pkg::USER_START + free_words - 10'h001;
  wire       take = req_valid && req_ready;
  wire       user = req.bank == sap_pkg::USER_BANK;
  wire       redir = take && user && req.addr == sap_pkg::REDIRECT_ADDR;
  wire       adv = ctrl_word[0];
  wire       slock = ctrl_word[1];
  wire       wrap = ctrl_word[2];
  wire       wrap_ok = ctrl_word[3];
  wire       mid = ptr >= sap_pkg::USER_START && ptr < last;
  wire [13:0] lo = {sap_pkg::ADDR_HI_ZERO, sap_pkg::USER_START};
  a_one_answer: assert property (take |=> resp_ok != resp_err)
    else $error("request answered by neither or both responses");
  a_no_stray: assert property (!take |=> !resp_ok && !resp_err)
    else $error("response without a request");
  a_other_bank: assert property (take && !user |=> resp_err)
    else $error("write outside the USER bank accepted");
  a_advance_first: assert property (redir && adv && mid |=>
    mem_we && mem_wr.addr == $past(ptr) + 10'h001 && ptr == mem_wr.addr)
    else $error("advancing write did not go to pointer plus one");
  a_wrap_return: assert property (redir && adv && wrap && !slock && ptr == last |=>
    mem_we && mem_wr.addr == sap_pkg::USER_START && wrap_ok)
    else $error("wrap did not return to the USER start");
  a_write_once: assert property (redir && adv && (!wrap || slock) && ptr == last |=>
    resp_err && !mem_we)
    else $error("write past the end accepted");
  a_hold_pointer: assert property (redir && !adv && !slock && mid |=>
    mem_wr.addr == $past(ptr) && $stable(pointer_word))
    else $error("non-advancing write moved the pointer");
  a_span_reject: assert property (take && user && slock && req.addr >= lo &&
    req.addr <= {sap_pkg::ADDR_HI_ZERO, ptr} |=> resp_err && !mem_we)
    else $error("write inside the locked span accepted");
  a_block_words: assert property (block_words == 8'h01 << ctrl_word[6:4])
    else $error("block size decode wrong");
  a_reserved_zero: assert property (pointer_word[13:10] == 4'h0)
    else $error("reserved pointer bits not zero");
  a_enable_frozen: assert property (!(nv_rd_req && nv_rd_valid) |=>
    $stable(multi_word_write_enable))
    else $error("multi-word enable changed outside the power-on load");
endmodule
bind stored_address_pointer_ctrl sap_checker u_chk (.mclk(mclk), .rstn(rstn),
  .nv_rd_req(nv_rd_req), .nv_rd_valid(nv_rd_valid), .req_valid(req_valid),
  .req_ready(req_ready), .req(req), .resp_ok(resp_ok), .resp_err(resp_err), .mem_we(mem_we),
  .mem_wr(mem_wr), .ctrl_word(ctrl_word), .pointer_word(pointer_word),
  .multi_word_write_enable(multi_word_write_enable), .block_words(block_words),
  .free_words(free_words));

// *** bench/interrogator_model.sv ***
// Far side of the controller: the party issuing single-word writes and the NVM image.
// Assumes the controller samples on the rising edge; this model moves on the falling one.
`timescale 1ns/1ps
module interrogator_model (
  // Clock
  input wire logic         mclk,
  // Power-on load
  input wire logic         nv_rd_req,
  output logic             nv_rd_valid,
  output logic [15:0]      nv_ctrl_word,
  output logic [15:0]      nv_ptr_word,
  // Write requests
  output logic             req_valid,
  input wire logic         req_ready,
  output sap_pkg::wr_req_s req,
  input wire logic         resp_ok
);
  logic [15:0] ctrl_img = 16'h00D1;
  logic [15:0] ptr_img = 16'h0006;
  logic [1:0]  wait_cnt = 2'h0;
  initial
  begin
    req_valid = 1'b0;
    req = '0;
  end
  // The NVM answers late so the controller has to wait for it.
  always @(negedge mclk)
  begin
    wait_cnt <= nv_rd_req ? wait_cnt + 2'h1 : 2'h0;
    nv_rd_valid <= nv_rd_req && wait_cnt == 2'h2;
  end
  // Outside the valid cycle the words are inverted so a stale sample cannot match.
  assign nv_ctrl_word = nv_rd_valid ? ctrl_img : ~ctrl_img;
  assign nv_ptr_word = nv_rd_valid ? ptr_img : ~ptr_img;
  task automatic xfer(input sap_pkg::wr_req_s r, output logic ok, output logic timed);
    int n;
    n = 0;
    @(negedge mclk);
    req <= r;
    req_valid <= 1'b1;
    while (!req_ready && n < 50)
    begin
      @(negedge mclk);
      n++;
    end
    @(negedge mclk);
    timed = n == 50;
    ok = resp_ok;
    req_valid <= 1'b0;
    req <= ~r;
  endtask
endmodule

// *** bench/tb_top.sv ***
// Self-checking bench for the stored address pointer controller.
// Assumes the far-side model serves the NVM load and carries out each write.
`timescale 1ns/1ps
module tb_top;
  logic             mclk = 1'b0;
  logic             rstn = 1'b0;
  logic             secured = 1'b0;
  int               num_errors = 0;
  int               compares = 0;
  logic             nv_rd_req, nv_rd_valid, req_valid, req_ready, resp_ok, mem_we;
  logic [15:0]      nv_ctrl_word, nv_ptr_word, ctrl_word, pointer_word;
  logic [9:0]       initial_pointer, free_words;
  logic [7:0]       block_words;
  logic             multi_word_write_enable, wrap_occurred_flag;
  sap_pkg::wr_req_s req;
  sap_pkg::mem_wr_s mem_wr;
  always #2.5 mclk = ~mclk;
  stored_address_pointer_ctrl DUT (.mclk(mclk), .rstn(rstn), .nv_rd_req(nv_rd_req),
    .nv_rd_valid(nv_rd_valid), .nv_ctrl_word(nv_ctrl_word), .nv_ptr_word(nv_ptr_word),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .secured(secured),
    .resp_ok(resp_ok), .resp_err(), .mem_we(mem_we), .mem_wr(mem_wr),
    .ctrl_word(ctrl_word), .pointer_word(pointer_word), .initial_pointer(initial_pointer),
    .multi_word_write_enable(multi_word_write_enable), .block_words(block_words),
    .free_words(free_words), .wrap_occurred_flag(wrap_occurred_flag));
  interrogator_model far (.mclk(mclk), .nv_rd_req(nv_rd_req), .nv_rd_valid(nv_rd_valid),
    .nv_ctrl_word(nv_ctrl_word), .nv_ptr_word(nv_ptr_word), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .resp_ok(resp_ok));
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  task automatic wr(input logic [13:0] a, input logic [15:0] d, input logic exp_ok,
                    input logic [1:0] b = sap_pkg::USER_BANK);
    logic ok;
    logic timed;
    far.xfer('{b, a, d}, ok, timed);
    if (timed)
    begin
      num_errors++;
      summarize();
    end
    else
      chk(exp_ok, ok);
  endtask
  task automatic t_init();
    chk(16'h0006, pointer_word);
    chk(10'h006, initial_pointer);
    chk(16'h00D1, ctrl_word);
    chk(1'b1, multi_word_write_enable);
    chk(8'h20, block_words);
    chk(10'h3E1, free_words);
    $display("test init done");
  endtask
  task automatic t_redirect();
    wr(14'h3FFF, 16'hA5A5, 1'b1);
    chk({10'h007, 16'hA5A5}, mem_wr);
    wr(14'h3FFF, 16'h5A5A, 1'b1);
    chk({10'h008, 16'h5A5A}, mem_wr);
    wr(14'h0003, 16'h0410, 1'b1);
    chk(16'h0010, pointer_word);
    chk(10'h010, initial_pointer);
    $display("test redirect done");
  endtask
  task automatic t_wrap();
    wr(14'h0003, 16'h03E6, 1'b1);
    wr(14'h0002, 16'h00D5, 1'b1);
    wr(14'h3FFF, 16'hC0DE, 1'b1);
    chk({10'h006, 16'hC0DE}, mem_wr);
    chk(16'h0006, pointer_word);
    chk(1'b1, wrap_occurred_flag);
    wr(14'h0002, 16'h00D5, 1'b1);
    chk(1'b0, wrap_occurred_flag);
    wr(14'h0002, 16'h00D1, 1'b1);
    wr(14'h0003, 16'h03E6, 1'b1);
    wr(14'h3FFF, 16'h1234, 1'b0);
    chk(16'h03E6, pointer_word);
    $display("test wrap done");
  endtask
  task automatic t_span();
    wr(14'h0002, 16'h00D3, 1'b1);
    wr(14'h0003, 16'h0010, 1'b1);
    wr(14'h0008, 16'h1111, 1'b0);
    wr(14'h0010, 16'h2222, 1'b0);
    wr(14'h0011, 16'h3333, 1'b1);
    wr(14'h0002, 16'h00D7, 1'b1);
    wr(14'h0003, 16'h03E6, 1'b1);
    wr(14'h3FFF, 16'h4444, 1'b0);
    $display("test span done");
  endtask
  task automatic t_hold();
    wr(14'h0002, 16'h0050, 1'b1);
    chk(1'b1, multi_word_write_enable);
    chk(8'h20, block_words);
    wr(14'h0003, 16'h0010, 1'b1);
    wr(14'h3FFF, 16'hBEEF, 1'b1);
    chk({10'h010, 16'hBEEF}, mem_wr);
    chk(16'h0010, pointer_word);
    // A word locked to the secured state refuses open writes and takes secured ones.
    wr(14'h0003, 16'h8020, 1'b1);
    wr(14'h0003, 16'h8030, 1'b0);
    secured = 1'b1;
    wr(14'h0003, 16'h8030, 1'b1);
    chk(16'h8030, pointer_word);
    wr(14'h3FFF, 16'h5555, 1'b0, 2'h1);
    wr(14'h0002, 16'hC050, 1'b1);
    wr(14'h0002, 16'h0050, 1'b0);
    chk(16'hC050, ctrl_word);
    $display("test hold done");
  endtask
  initial
  begin
    repeat (8) @(negedge mclk);
    rstn = 1'b1;
    for (int i = 0; i < 20 && req_ready !== 1'b1; i++)
      @(negedge mclk);
    chk(1'b1, req_ready);
    if (req_ready !== 1'b1)
      summarize();
    t_init();
    t_redirect();
    t_wrap();
    t_span();
    t_hold();
    summarize();
  end
endmodule
